// ### hdl/dag_consts.svh
// constants for the data address generator: pointer register indices, widths, steps
// assumes inclusion by bare name from every design module file
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH
`define DAG_ADDR_W 16
`define DAG_BYTE_STEP 16'h0001
`define DAG_WORD_STEP 16'h0002
`define DAG_X_PTR_A 4'h8
`define DAG_X_PTR_B 4'h9
`define DAG_Y_PTR_A 4'hA
`define DAG_Y_PTR_B 4'hB
`define DAG_BREV_W 4
`define DAG_ACC_GUARD_W 8
`endif

// ### hdl/dag_pkg.sv
// types for the data address generator
// assumes no other package
package dag_pkg;
  typedef enum logic [2:0] {
    DAG_MODE_NONE = 3'h0,
    DAG_MODE_PREINC = 3'h1,
    DAG_MODE_PREDEC = 3'h2,
    DAG_MODE_POSTINC = 3'h3,
    DAG_MODE_POSTDEC = 3'h4,
    DAG_MODE_REGOFS = 3'h5,
    DAG_MODE_LITOFS = 3'h6
  } dag_mode_e;
  typedef enum logic [2:0] {
    DAG_PF_NONE = 3'h0,
    DAG_PF_INC2 = 3'h1,
    DAG_PF_INC4 = 3'h2,
    DAG_PF_INC6 = 3'h3,
    DAG_PF_DEC2 = 3'h4,
    DAG_PF_DEC4 = 3'h5,
    DAG_PF_DEC6 = 3'h6
  } dag_pf_e;
  typedef enum logic [1:0] {
    DAG_WRAP_LINEAR = 2'h0,
    DAG_WRAP_MODULO = 2'h1,
    DAG_WRAP_BITREV = 2'h2
  } dag_wrap_e;
  typedef enum logic [3:0] {
    DAG_IMM_1U = 4'h0,
    DAG_IMM_4U = 4'h1,
    DAG_IMM_4S = 4'h2,
    DAG_IMM_5U = 4'h3,
    DAG_IMM_6S = 4'h4,
    DAG_IMM_8U = 4'h5,
    DAG_IMM_10U = 4'h6,
    DAG_IMM_10S = 4'h7,
    DAG_IMM_14U = 4'h8,
    DAG_IMM_15U = 4'h9,
    DAG_IMM_16U = 4'hA
  } dag_imm_e;
  typedef enum logic [1:0] {
    DAG_ST_IDLE = 2'h0,
    DAG_ST_BUSY = 2'h1
  } dag_state_e;
endpackage

// ### hdl/dag_ptr_update.sv
// pointer modifier: step plus modulo or bit-reversed wrap
// assumes combinational use by dag_top, same clock
`timescale 1ns/1ps
`include "dag_consts.svh"
module dag_ptr_update (
  // pointer and step
  input wire logic [15:0] ptr,
  input wire logic [15:0] step,
  input wire logic down,
  // wrap control
  input wire dag_pkg::dag_wrap_e wrap,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  // result
  output logic [15:0] ptr_next
);
  logic [15:0] lin;
  logic [15:0] rev;
  // linear step wraps in the 16-bit space
  always_comb begin
    lin = down ? ptr - step : ptr + step;
  end
  // bit reversal of the low word-index bits, then stepped
  genvar i;
  generate
    for (i = 0; i < `DAG_BREV_W; i++) begin : g_rev
      assign rev[i + 1] = ptr[`DAG_BREV_W - i];
    end
  endgenerate
  assign rev[0] = ptr[0];
  assign rev[15:`DAG_BREV_W + 1] = ptr[15:`DAG_BREV_W + 1];
  // select the wrap policy
  always_comb begin
    ptr_next = lin;
    case (wrap)
      dag_pkg::DAG_WRAP_MODULO: begin
        if (!down && ptr == mod_end) begin
          ptr_next = mod_start; // RULE_08
        end else if (down && ptr == mod_start) begin
          ptr_next = mod_end; // RULE_08
        end
      end
      dag_pkg::DAG_WRAP_BITREV: begin
        ptr_next = rev + step; // RULE_09
      end
      default: begin
        ptr_next = lin;
      end
    endcase
  end
endmodule

// ### hdl/dag_imm_extract.sv
// immediate field extraction with sign or zero extension
// assumes the instruction word holds the field in its low bits
`timescale 1ns/1ps
`include "dag_consts.svh"
module dag_imm_extract (
  // instruction field and width select
  input wire logic [15:0] field,
  input wire dag_pkg::dag_imm_e kind,
  // extended operand
  output logic [15:0] imm
);
  // width per type; signed forms sign-extend, others zero-extend
  always_comb begin
    case (kind)
      dag_pkg::DAG_IMM_1U: imm = {15'h0000, field[0]}; // RULE_11
      dag_pkg::DAG_IMM_4U: imm = {12'h000, field[3:0]}; // RULE_13
      dag_pkg::DAG_IMM_4S: imm = {{12{field[3]}}, field[3:0]}; // RULE_12
      dag_pkg::DAG_IMM_5U: imm = {11'h000, field[4:0]}; // RULE_16
      dag_pkg::DAG_IMM_6S: imm = {{10{field[5]}}, field[5:0]}; // RULE_14
      dag_pkg::DAG_IMM_8U: imm = {8'h00, field[7:0]};
      dag_pkg::DAG_IMM_10U: imm = {6'h00, field[9:0]}; // RULE_16
      dag_pkg::DAG_IMM_10S: imm = {{6{field[9]}}, field[9:0]}; // RULE_12
      dag_pkg::DAG_IMM_14U: imm = {2'h0, field[13:0]}; // RULE_15
      dag_pkg::DAG_IMM_15U: imm = {1'h0, field[14:0]}; // RULE_15
      dag_pkg::DAG_IMM_16U: imm = field;
      default: imm = 16'h0000;
    endcase
  end
endmodule

// ### hdl/dag_top.sv
// data address generator: effective addresses, pointer updates,
// immediates and accumulator load data for one instruction per request
// assumes decode supplies register contents and modes with a valid pulse
// Function
// RULE_01 - literal move address is register plus signed10
// RULE_02 - five pointer modes for indirect instructions
// RULE_03 - register offset only for move/accumulator ops
// RULE_04 - two prefetches, X and Y, per MAC
// RULE_05 - prefetch post-step 2, 4 or 6 bytes
// RULE_06 - prefetch steps are word-sized only
// RULE_07 - X pointers eight/nine, Y ten/eleven only
// RULE_08 - modulo wrap at buffer boundary in hardware
// RULE_09 - bit-reversed pointer stepping for radix-2
// RULE_10 - modulo/bit-reverse usable by any indirect
// RULE_11 - immediates of 1 to 16 bits extracted
// RULE_12 - signed 4, 6, 10 sign-extended; others zero
// RULE_13 - bit ops take 4-bit bit position
// RULE_14 - accumulator ops signed 4, shift signed 6
// RULE_15 - counts 14 bits, 15 on one variant
// RULE_16 - ALU literals unsigned 10 or 5 bits
// RULE_17 - accumulator load: middle word, sign, zero low
// RULE_18 - step 1 for bytes, 2 for words
// RULE_19 - register offset unscaled, registers unchanged
// RULE_20 - literal base unchanged, 16-bit wrap
// RULE_21 - source and destination pointers updated independently
`timescale 1ns/1ps
`include "dag_consts.svh"
module dag_top #(
  parameter bit LONG_LOOP_COUNT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request from decode
  input wire logic req_valid,
  input wire logic byte_mode,
  input wire logic move_op,
  input wire logic accumulator_op,
  input wire logic loop_count_op,
  // source operand
  input wire dag_pkg::dag_mode_e src_mode,
  input wire logic [3:0] src_reg_idx,
  input wire logic [15:0] src_ptr,
  input wire logic [15:0] src_ofs,
  input wire dag_pkg::dag_wrap_e src_wrap,
  // destination operand
  input wire dag_pkg::dag_mode_e dst_mode,
  input wire logic [3:0] dst_reg_idx,
  input wire logic [15:0] dst_ptr,
  input wire logic [15:0] dst_ofs,
  input wire dag_pkg::dag_wrap_e dst_wrap,
  // prefetch operands
  input wire logic mac_op,
  input wire logic [3:0] x_reg_idx,
  input wire logic [15:0] x_ptr,
  input wire dag_pkg::dag_pf_e x_pf,
  input wire dag_pkg::dag_wrap_e x_wrap,
  input wire logic [3:0] y_reg_idx,
  input wire logic [15:0] y_ptr,
  input wire dag_pkg::dag_pf_e y_pf,
  input wire dag_pkg::dag_wrap_e y_wrap,
  // modulo buffer bounds
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  // immediate operand
  input wire logic [15:0] imm_field,
  input wire dag_pkg::dag_imm_e imm_kind,
  // accumulator load
  input wire logic acc_load,
  input wire logic [15:0] acc_word,
  // addresses out
  output logic out_valid,
  output logic mode_error,
  output logic [15:0] src_effective_address,
  output logic [15:0] dst_effective_address,
  output logic [15:0] x_effective_address,
  output logic [15:0] y_effective_address,
  // pointer write-backs
  output logic src_wb,
  output logic [15:0] src_ptr_new,
  output logic dst_wb,
  output logic [15:0] dst_ptr_new,
  output logic x_wb,
  output logic [15:0] x_ptr_new,
  output logic y_wb,
  output logic [15:0] y_ptr_new,
  // immediate and accumulator data
  output logic [15:0] imm_value,
  output logic [39:0] acc_value
);
  // ----------------------------------------------------------------
  // operand step and mode checks
  // ----------------------------------------------------------------
  logic [15:0] step;
  logic src_bad;
  logic dst_bad;
  logic x_bad;
  logic y_bad;
  logic bad;
  logic x_en;
  logic y_en;

  // byte ops step by one, words by two
  assign step = byte_mode ? `DAG_BYTE_STEP : `DAG_WORD_STEP; // RULE_18

  // offset modes limited by instruction class
  assign src_bad = (src_mode == dag_pkg::DAG_MODE_REGOFS && !(move_op || accumulator_op))
    || (src_mode == dag_pkg::DAG_MODE_LITOFS && !move_op); // RULE_03
  assign dst_bad = (dst_mode == dag_pkg::DAG_MODE_REGOFS && !(move_op || accumulator_op))
    || (dst_mode == dag_pkg::DAG_MODE_LITOFS && !move_op); // RULE_03

  // prefetch pointer register restrictions
  assign x_bad = mac_op && x_pf != dag_pkg::DAG_PF_NONE
    && x_reg_idx != `DAG_X_PTR_A && x_reg_idx != `DAG_X_PTR_B; // RULE_07
  assign y_bad = mac_op && y_pf != dag_pkg::DAG_PF_NONE
    && y_reg_idx != `DAG_Y_PTR_A && y_reg_idx != `DAG_Y_PTR_B; // RULE_07
  assign bad = src_bad || dst_bad || x_bad || y_bad;
  assign x_en = mac_op && !x_bad;
  assign y_en = mac_op && !y_bad;

  // ----------------------------------------------------------------
  // indirect operand address and pointer update
  // ----------------------------------------------------------------
  logic [15:0] src_mod;
  logic [15:0] dst_mod;
  logic src_pre;
  logic dst_pre;
  logic src_dn;
  logic dst_dn;
  logic [15:0] next_src_ea;
  logic [15:0] next_dst_ea;
  logic next_src_wb;
  logic next_dst_wb;

  assign src_dn = src_mode == dag_pkg::DAG_MODE_PREDEC || src_mode == dag_pkg::DAG_MODE_POSTDEC;
  assign dst_dn = dst_mode == dag_pkg::DAG_MODE_PREDEC || dst_mode == dag_pkg::DAG_MODE_POSTDEC;
  assign src_pre = src_mode == dag_pkg::DAG_MODE_PREINC || src_mode == dag_pkg::DAG_MODE_PREDEC;
  assign dst_pre = dst_mode == dag_pkg::DAG_MODE_PREINC || dst_mode == dag_pkg::DAG_MODE_PREDEC;

  // one modifier per indirect pointer
  dag_ptr_update u_src_upd (
    .ptr(src_ptr),
    .step(step),
    .down(src_dn),
    .wrap(src_wrap),
    .mod_start(mod_start),
    .mod_end(mod_end),
    .ptr_next(src_mod)
  ); // RULE_10
  dag_ptr_update u_dst_upd (
    .ptr(dst_ptr),
    .step(step),
    .down(dst_dn),
    .wrap(dst_wrap),
    .mod_start(mod_start),
    .mod_end(mod_end),
    .ptr_next(dst_mod)
  ); // RULE_21

  // source address and write-back per mode
  always_comb begin
    next_src_wb = 1'b0;
    case (src_mode)
      dag_pkg::DAG_MODE_NONE: next_src_ea = src_ptr; // RULE_02
      dag_pkg::DAG_MODE_PREINC,
      dag_pkg::DAG_MODE_PREDEC,
      dag_pkg::DAG_MODE_POSTINC,
      dag_pkg::DAG_MODE_POSTDEC: begin
        next_src_ea = src_pre ? src_mod : src_ptr; // RULE_02
        next_src_wb = 1'b1;
      end
      dag_pkg::DAG_MODE_REGOFS: next_src_ea = src_ptr + src_ofs; // RULE_19
      dag_pkg::DAG_MODE_LITOFS:
        next_src_ea = src_ptr + {{6{src_ofs[9]}}, src_ofs[9:0]}; // RULE_01
      default: next_src_ea = src_ptr;
    endcase
  end

  // destination address and write-back per mode
  always_comb begin
    next_dst_wb = 1'b0;
    case (dst_mode)
      dag_pkg::DAG_MODE_NONE: next_dst_ea = dst_ptr;
      dag_pkg::DAG_MODE_PREINC,
      dag_pkg::DAG_MODE_PREDEC,
      dag_pkg::DAG_MODE_POSTINC,
      dag_pkg::DAG_MODE_POSTDEC: begin
        next_dst_ea = dst_pre ? dst_mod : dst_ptr; // RULE_02
        next_dst_wb = 1'b1; // RULE_21
      end
      dag_pkg::DAG_MODE_REGOFS: next_dst_ea = dst_ptr + dst_ofs; // RULE_19
      dag_pkg::DAG_MODE_LITOFS:
        next_dst_ea = dst_ptr + {{6{dst_ofs[9]}}, dst_ofs[9:0]}; // RULE_20
      default: next_dst_ea = dst_ptr;
    endcase
  end

  // ----------------------------------------------------------------
  // X and Y prefetch pointers
  // ----------------------------------------------------------------
  logic [15:0] x_step;
  logic [15:0] y_step;
  logic x_dn;
  logic y_dn;
  logic [15:0] x_mod;
  logic [15:0] y_mod;

  // word-only steps of 2, 4 or 6 bytes
  function automatic logic [15:0] pf_step(input dag_pkg::dag_pf_e pf);
    case (pf)
      dag_pkg::DAG_PF_INC2, dag_pkg::DAG_PF_DEC2: pf_step = 16'h0002; // RULE_06
      dag_pkg::DAG_PF_INC4, dag_pkg::DAG_PF_DEC4: pf_step = 16'h0004;
      dag_pkg::DAG_PF_INC6, dag_pkg::DAG_PF_DEC6: pf_step = 16'h0006;
      default: pf_step = 16'h0000;
    endcase
  endfunction

  assign x_step = pf_step(x_pf); // RULE_05
  assign y_step = pf_step(y_pf); // RULE_05
  assign x_dn = x_pf == dag_pkg::DAG_PF_DEC2 || x_pf == dag_pkg::DAG_PF_DEC4
    || x_pf == dag_pkg::DAG_PF_DEC6;
  assign y_dn = y_pf == dag_pkg::DAG_PF_DEC2 || y_pf == dag_pkg::DAG_PF_DEC4
    || y_pf == dag_pkg::DAG_PF_DEC6;

  dag_ptr_update u_x_upd (
    .ptr(x_ptr),
    .step(x_step),
    .down(x_dn),
    .wrap(x_wrap),
    .mod_start(mod_start),
    .mod_end(mod_end),
    .ptr_next(x_mod)
  ); // RULE_04
  dag_ptr_update u_y_upd (
    .ptr(y_ptr),
    .step(y_step),
    .down(y_dn),
    .wrap(y_wrap),
    .mod_start(mod_start),
    .mod_end(mod_end),
    .ptr_next(y_mod)
  ); // RULE_04

  // ----------------------------------------------------------------
  // immediate and accumulator data
  // ----------------------------------------------------------------
  logic [15:0] imm_raw;
  dag_pkg::dag_imm_e imm_sel;

  // long-count variant widens the count
  assign imm_sel = (loop_count_op && LONG_LOOP_COUNT) ? dag_pkg::DAG_IMM_15U
    : (loop_count_op ? dag_pkg::DAG_IMM_14U : imm_kind); // RULE_15

  dag_imm_extract u_imm (
    .field(imm_field),
    .kind(imm_sel),
    .imm(imm_raw)
  ); // RULE_11

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // handshake and error flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      mode_error <= 1'b0;
    end else begin
      out_valid <= req_valid && !bad;
      mode_error <= req_valid && bad; // RULE_03
    end
  end

  // operand addresses and write-backs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_effective_address <= 16'h0000;
      dst_effective_address <= 16'h0000;
      src_wb <= 1'b0;
      dst_wb <= 1'b0;
      src_ptr_new <= 16'h0000;
      dst_ptr_new <= 16'h0000;
    end else begin
      src_effective_address <= next_src_ea;
      dst_effective_address <= next_dst_ea;
      src_wb <= req_valid && !bad && next_src_wb; // RULE_19
      dst_wb <= req_valid && !bad && next_dst_wb; // RULE_21
      src_ptr_new <= src_mod;
      dst_ptr_new <= dst_mod;
    end
  end

  // prefetch addresses taken before the post-step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_effective_address <= 16'h0000;
      y_effective_address <= 16'h0000;
      x_wb <= 1'b0;
      y_wb <= 1'b0;
      x_ptr_new <= 16'h0000;
      y_ptr_new <= 16'h0000;
    end else begin
      x_effective_address <= x_ptr; // RULE_05
      y_effective_address <= y_ptr;
      x_wb <= req_valid && !bad && x_en && x_pf != dag_pkg::DAG_PF_NONE; // RULE_04
      y_wb <= req_valid && !bad && y_en && y_pf != dag_pkg::DAG_PF_NONE;
      x_ptr_new <= x_mod;
      y_ptr_new <= y_mod;
    end
  end

  // immediate value and accumulator load image
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      imm_value <= 16'h0000;
      acc_value <= 40'h00_0000_0000;
    end else begin
      imm_value <= imm_raw; // RULE_12
      if (req_valid && acc_load) begin
        acc_value <= {{`DAG_ACC_GUARD_W{acc_word[15]}}, acc_word, 16'h0000}; // RULE_17
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_lit_offset: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    req_valid && !bad && src_mode == dag_pkg::DAG_MODE_LITOFS |=>
    src_effective_address == $past(src_ptr) + {{6{$past(src_ofs[9])}}, $past(src_ofs[9:0])})
    else $error("literal offset address wrong");
  chk_post_ea: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    req_valid && src_mode == dag_pkg::DAG_MODE_POSTINC |=> src_effective_address == $past(src_ptr))
    else $error("post mode address not original pointer");
  chk_regofs_legal: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    req_valid && src_mode == dag_pkg::DAG_MODE_REGOFS && !move_op && !accumulator_op
    |=> mode_error && !out_valid)
    else $error("register offset accepted on wrong op");
  chk_pf_step: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    req_valid && !bad && mac_op && x_pf == dag_pkg::DAG_PF_INC6 && x_wrap == dag_pkg::DAG_WRAP_LINEAR
    |=> x_wb && x_ptr_new == $past(x_ptr) + 16'h0006)
    else $error("x prefetch step wrong");
  chk_pf_even: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    req_valid && mac_op && y_wrap == dag_pkg::DAG_WRAP_LINEAR |=> y_ptr_new[0] == $past(y_ptr[0]))
    else $error("odd prefetch step");
  chk_x_reg: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    x_wb |-> $past(x_reg_idx) == `DAG_X_PTR_A || $past(x_reg_idx) == `DAG_X_PTR_B)
    else $error("illegal x pointer register");
  chk_byte_step: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
    req_valid && !bad && byte_mode && dst_mode == dag_pkg::DAG_MODE_PREINC
    && dst_wrap == dag_pkg::DAG_WRAP_LINEAR
    |=> dst_effective_address == $past(dst_ptr) + 16'h0001 && dst_wb)
    else $error("byte pre-increment wrong");
  chk_regofs_nowb: assert property (@(posedge clk) disable iff (sys_rst) // RULE_19
    req_valid && src_mode == dag_pkg::DAG_MODE_REGOFS |=> !src_wb)
    else $error("register offset modified pointer");
  chk_acc_load: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
    req_valid && acc_load |=> acc_value[15:0] == 16'h0000
    && acc_value[39:32] == {8{$past(acc_word[15])}})
    else $error("accumulator load image wrong");
  cov_mac: cover property (@(posedge clk) x_wb && y_wb);
  cov_both: cover property (@(posedge clk) src_wb && dst_wb);
  cov_err: cover property (@(posedge clk) mode_error);
  cov_acc: cover property (@(posedge clk) req_valid && acc_load);
endmodule

// ### sim/dag_exec_model.sv
// execute-side model: working registers fed by pointer write-backs
// assumes one clock shared with dag_top and indices held with req_valid
`timescale 1ns/1ps
module dag_exec_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request indices
  input wire logic req_valid,
  input wire logic [3:0] src_idx,
  input wire logic [3:0] dst_idx,
  // write-backs
  input wire logic src_wb,
  input wire logic [15:0] src_new,
  input wire logic dst_wb,
  input wire logic [15:0] dst_new,
  // register contents
  output logic [15:0] wreg [16]
);
  logic [3:0] s_q;
  logic [3:0] d_q;
  // remember which registers the request named
  always_ff @(posedge clk) begin
    if (req_valid) begin
      s_q <= src_idx;
      d_q <= dst_idx;
    end
  end
  // both write-backs in one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        wreg[i] <= 16'h2000 + 16'(i * 16);
      end
    end else begin
      if (src_wb) wreg[s_q] <= src_new;
      if (dst_wb) wreg[d_q] <= dst_new;
    end
  end
endmodule

// ### sim/data_address_generator_bench.sv
// self-checking bench for dag_top: random and corner requests
// assumes dag_pkg and the execute model are compiled first
`timescale 1ns/1ps
module data_address_generator_bench;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
  logic byte_mode, move_op, accumulator_op, loop_count_op, mac_op, acc_load;
  logic [3:0] src_reg_idx, dst_reg_idx, x_reg_idx, y_reg_idx;
  logic [15:0] src_ptr, src_ofs, dst_ptr, dst_ofs, x_ptr, y_ptr;
  logic [15:0] mod_start, mod_end, imm_field, acc_word, imm_value;
  logic [15:0] src_ea, dst_ea, x_ea, y_ea, src_pn, dst_pn, x_pn, y_pn;
  logic out_valid, mode_error, src_wb, dst_wb, x_wb, y_wb;
  logic [39:0] acc_value;
  logic [15:0] wreg [16];
  dag_pkg::dag_mode_e src_mode, dst_mode;
  dag_pkg::dag_wrap_e src_wrap, dst_wrap, x_wrap, y_wrap;
  dag_pkg::dag_pf_e x_pf, y_pf;
  dag_pkg::dag_imm_e imm_kind;
  logic [31:0] rng = 32'h336B;
  int n_fail = 0, cmp_count = 0;
  logic [32:0] e, f;
  logic [15:0] lp [4] = '{16'h1200, 16'h2944, 16'hFFF0, 16'h0005};
  logic [9:0] lo [4] = '{10'h020, 10'h200, 10'h020, 10'h3FF};
  logic [15:0] le [4] = '{16'h1220, 16'h2744, 16'h0010, 16'h0004};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  dag_top #(.LONG_LOOP_COUNT(1'b0)) dag_top_i (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .byte_mode(byte_mode),
    .move_op(move_op), .accumulator_op(accumulator_op), .loop_count_op(loop_count_op),
    .src_mode(src_mode), .src_reg_idx(src_reg_idx), .src_ptr(src_ptr), .src_ofs(src_ofs),
    .src_wrap(src_wrap), .dst_mode(dst_mode), .dst_reg_idx(dst_reg_idx), .dst_ptr(dst_ptr),
    .dst_ofs(dst_ofs), .dst_wrap(dst_wrap), .mac_op(mac_op), .x_reg_idx(x_reg_idx),
    .x_ptr(x_ptr), .x_pf(x_pf), .x_wrap(x_wrap), .y_reg_idx(y_reg_idx), .y_ptr(y_ptr),
    .y_pf(y_pf), .y_wrap(y_wrap), .mod_start(mod_start), .mod_end(mod_end),
    .imm_field(imm_field), .imm_kind(imm_kind), .acc_load(acc_load), .acc_word(acc_word),
    .out_valid(out_valid), .mode_error(mode_error), .src_effective_address(src_ea),
    .dst_effective_address(dst_ea), .x_effective_address(x_ea), .y_effective_address(y_ea),
    .src_wb(src_wb), .src_ptr_new(src_pn), .dst_wb(dst_wb), .dst_ptr_new(dst_pn),
    .x_wb(x_wb), .x_ptr_new(x_pn), .y_wb(y_wb), .y_ptr_new(y_pn),
    .imm_value(imm_value), .acc_value(acc_value)
  );

  dag_exec_model dag_exec_model_i (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .src_idx(src_reg_idx),
    .dst_idx(dst_reg_idx), .src_wb(src_wb), .src_new(src_pn), .dst_wb(dst_wb),
    .dst_new(dst_pn), .wreg(wreg)
  );

  // ------------------------------
  // expectations and drivers
  // ------------------------------
  function automatic logic [15:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction

  // {wb, new pointer, address}, linear indirect mode
  function automatic logic [32:0] ind(dag_pkg::dag_mode_e m, logic [15:0] p, logic b);
    logic [15:0] s;
    s = b ? 16'h0001 : 16'h0002;
    case (m)
      dag_pkg::DAG_MODE_PREINC: return {1'b1, p + s, p + s};
      dag_pkg::DAG_MODE_PREDEC: return {1'b1, p - s, p - s};
      dag_pkg::DAG_MODE_POSTINC: return {1'b1, p + s, p};
      dag_pkg::DAG_MODE_POSTDEC: return {1'b1, p - s, p};
      default: return {1'b0, p, p};
    endcase
  endfunction

  // prefetch: codes 1..3 add, 4..6 subtract 2/4/6
  function automatic logic [32:0] pfx(int c, logic [15:0] p);
    logic [15:0] k;
    k = 16'((c - 1) % 3 * 2 + 2);
    if (c == 0) return {1'b0, p, p};
    return {1'b1, c > 3 ? p - k : p + k, p};
  endfunction

  function automatic logic [15:0] imx(dag_pkg::dag_imm_e k, logic [15:0] v);
    case (k)
      dag_pkg::DAG_IMM_1U: return {15'h0, v[0]};
      dag_pkg::DAG_IMM_4U: return {12'h0, v[3:0]};
      dag_pkg::DAG_IMM_4S: return {{12{v[3]}}, v[3:0]};
      dag_pkg::DAG_IMM_5U: return {11'h0, v[4:0]};
      dag_pkg::DAG_IMM_6S: return {{10{v[5]}}, v[5:0]};
      dag_pkg::DAG_IMM_8U: return {8'h0, v[7:0]};
      dag_pkg::DAG_IMM_10U: return {6'h0, v[9:0]};
      dag_pkg::DAG_IMM_10S: return {{6{v[9]}}, v[9:0]};
      dag_pkg::DAG_IMM_14U: return {2'h0, v[13:0]};
      dag_pkg::DAG_IMM_15U: return {1'b0, v[14:0]};
      default: return v;
    endcase
  endfunction

  task automatic chk(input logic [39:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic chk3(input logic [32:0] x, logic wb, logic [15:0] ea, logic [15:0] pn);
    chk(wb, x[32]);
    chk(ea, x[15:0]);
    if (x[32]) chk(pn, x[31:16]);
  endtask

  // neutral request fields
  task automatic idle();
    {byte_mode, move_op, accumulator_op, loop_count_op, mac_op, acc_load} = 6'h00;
    acc_word = 16'h0000;
    src_mode = dag_pkg::DAG_MODE_NONE;
    dst_mode = dag_pkg::DAG_MODE_NONE;
    src_wrap = dag_pkg::DAG_WRAP_LINEAR;
    dst_wrap = dag_pkg::DAG_WRAP_LINEAR;
    x_wrap = dag_pkg::DAG_WRAP_LINEAR;
    y_wrap = dag_pkg::DAG_WRAP_LINEAR;
    x_pf = dag_pkg::DAG_PF_NONE;
    y_pf = dag_pkg::DAG_PF_NONE;
    {src_reg_idx, dst_reg_idx, x_reg_idx, y_reg_idx} = 16'h048A;
    {src_ptr, dst_ptr, src_ofs, dst_ofs, x_ptr, y_ptr, mod_start, mod_end} = {112'h0, 16'hFFFF};
    imm_field = 16'h0000;
    imm_kind = dag_pkg::DAG_IMM_16U;
  endtask

  // one-cycle request; answer stands on return
  task automatic fire();
    @(negedge clk);
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    idle();
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(out_valid, 1'b0);
    chk(acc_value, 40'h0);
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      idle();
      src_reg_idx = 4'(nxt() % 4);
      dst_reg_idx = 4'(4 + nxt() % 4);
      src_ptr = wreg[src_reg_idx];
      dst_ptr = wreg[dst_reg_idx];
      src_mode = dag_pkg::dag_mode_e'(3'(nxt() % 5));
      dst_mode = dag_pkg::dag_mode_e'(3'(nxt() % 5));
      byte_mode = 1'(nxt());
      fire();
      e = ind(src_mode, src_ptr, byte_mode);
      f = ind(dst_mode, dst_ptr, byte_mode);
      chk(mode_error, 1'b0);
      chk3(e, src_wb, src_ea, src_pn);
      chk3(f, dst_wb, dst_ea, dst_pn);
      @(negedge clk);
      if (e[32]) chk(wreg[src_reg_idx], e[31:16]);
      if (f[32]) chk(wreg[dst_reg_idx], f[31:16]);
    end
    $display("indirect test done");
    idle();
    move_op = 1'b1;
    src_mode = dag_pkg::DAG_MODE_LITOFS;
    for (int i = 0; i < 4; i++) begin
      src_ptr = lp[i];
      src_ofs = {6'(nxt()), lo[i]};
      fire();
      chk(src_ea, le[i]);
      chk(src_wb, 1'b0);
    end
    move_op = 1'b0;
    fire();
    chk(mode_error, 1'b1);
    chk(src_wb, 1'b0);
    idle();
    move_op = 1'b1;
    byte_mode = 1'b1;
    src_mode = dag_pkg::DAG_MODE_REGOFS;
    src_ptr = 16'h2300;
    src_ofs = 16'h01FE;
    dst_mode = dag_pkg::DAG_MODE_POSTINC;
    dst_ptr = 16'h1000;
    fire();
    chk(src_ea, 16'h24FE);
    chk(src_wb, 1'b0);
    chk3(33'h1_1001_1000, dst_wb, dst_ea, dst_pn);
    idle();
    accumulator_op = 1'b1;
    src_mode = dag_pkg::DAG_MODE_REGOFS;
    src_ptr = 16'h2344;
    src_ofs = 16'h0008;
    acc_load = 1'b1;
    acc_word = 16'hE290;
    fire();
    chk(src_ea, 16'h234C);
    chk(acc_value, 40'hFF_E290_0000);
    acc_word = 16'h7877;
    fire();
    chk(acc_value, 40'h00_7877_0000);
    {accumulator_op, acc_load} = 2'h0;
    fire();
    chk(mode_error, 1'b1);
    chk(acc_value, 40'h00_7877_0000);
    $display("offset test done");
    for (int c = 0; c < 7; c++) begin
      idle();
      {mac_op, byte_mode} = 2'h3;
      x_reg_idx = 4'(8 + c % 2);
      y_reg_idx = 4'(10 + c % 2);
      x_pf = dag_pkg::dag_pf_e'(3'(c));
      y_pf = dag_pkg::dag_pf_e'(3'(6 - c));
      x_ptr = nxt() & 16'hFFFE;
      y_ptr = nxt() & 16'hFFFE;
      fire();
      chk(out_valid, 1'b1);
      chk3(pfx(c, x_ptr), x_wb, x_ea, x_pn);
      chk3(pfx(6 - c, y_ptr), y_wb, y_ea, y_pn);
    end
    x_reg_idx = 4'hA;
    fire();
    chk(mode_error, 1'b1);
    chk(x_wb, 1'b0);
    x_reg_idx = 4'h8;
    y_reg_idx = 4'h9;
    y_pf = dag_pkg::DAG_PF_INC2;
    fire();
    chk(mode_error, 1'b1);
    chk(y_wb, 1'b0);
    $display("prefetch test done");
    idle();
    mod_start = 16'h1000;
    mod_end = 16'h101E;
    src_wrap = dag_pkg::DAG_WRAP_MODULO;
    dst_wrap = dag_pkg::DAG_WRAP_MODULO;
    src_mode = dag_pkg::DAG_MODE_POSTINC;
    src_ptr = 16'h101E;
    dst_mode = dag_pkg::DAG_MODE_PREDEC;
    dst_ptr = 16'h1000;
    fire();
    chk3(33'h1_1000_101E, src_wb, src_ea, src_pn);
    chk3(33'h1_101E_101E, dst_wb, dst_ea, dst_pn);
    idle();
    src_wrap = dag_pkg::DAG_WRAP_BITREV;
    src_mode = dag_pkg::DAG_MODE_POSTINC;
    src_ptr = 16'h1002;
    fire();
    chk3(33'h1_1012_1002, src_wb, src_ea, src_pn);
    $display("wrap test done");
    for (int k = 0; k < 22; k++) begin
      idle();
      imm_kind = dag_pkg::dag_imm_e'(4'(k % 11));
      imm_field = k < 11 ? 16'hFFFF : nxt();
      fire();
      chk(imm_value, imx(imm_kind, imm_field));
    end
    loop_count_op = 1'b1;
    fire();
    chk(imm_value, {2'h0, imm_field[13:0]});
    $display("immediate test done");
    conclude();
  end
endmodule
